// [hw/cell_monitor_adc_control.sv]
// channel sequencing, reference selection and result registers
`timescale 1ns/1ps
`default_nettype none
module cell_monitor_adc_control #(
  parameter int TRIM_W = 8
) (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic                          reg_wr_en,
  input  wire logic [7:0]                    reg_wr_data,
  input  wire logic                          reg_rd_en,
  output logic      [7:0]                    reg_rd_data,
  input  wire logic                          host_start_pin,
  input  wire logic                          adc_done,
  input  wire logic [adc_ctrl_pkg::CODE_W-1:0] adc_code,
  input  wire logic signed [TRIM_W-1:0]      adc_trim,
  output adc_ctrl_pkg::mux_src_e             adc_mux_sel,
  output adc_ctrl_pkg::ref_src_e             adc_ref_sel,
  output logic                               adc_start,
  output logic      [1:0]                    therm_switch,
  output logic                               result_ready_out,
  output logic                               busy
);
  import adc_ctrl_pkg::*;

  // mask of channels the control register asks for, in scan order
  function automatic logic [CH_COUNT-1:0] enabled_mask(
    input logic [7:0] cc
  );
    logic [2:0] cnt;
    cnt = cc[CC_CELL_MSB:CC_CELL_LSB];
    // codes 6 and 7 have no meaning; treat them as all six cells
    if (cnt > CELL_COUNT_ALL) begin
      cnt = CELL_COUNT_ALL;
    end
    enabled_mask = '0;
    for (int i = 0; i < 6; i++) begin
      enabled_mask[i] = (3'(i) <= cnt);                         // [R17]
    end
    enabled_mask[CH_TS1] = cc[CC_TS1_BIT];                     // [R9]
    enabled_mask[CH_TS2] = cc[CC_TS2_BIT];                     // [R9]
    enabled_mask[CH_AUX] = cc[CC_AUX_BIT];
    return enabled_mask;
  endfunction

  // lowest enabled channel at or above from; CH_NONE when none is left
  function automatic logic [3:0] next_enabled(
    input logic [CH_COUNT-1:0] mask,
    input logic [3:0]          from
  );
    next_enabled = CH_NONE;
    for (int i = CH_COUNT - 1; i >= 0; i--) begin
      if (mask[i] && 4'(i) >= from) begin
        next_enabled = 4'(i);
      end
    end
    return next_enabled;
  endfunction

  // multiplexer source for a channel; aux is split by the source bit
  function automatic mux_src_e mux_for(
    input logic [3:0] ch,
    input logic [7:0] fc
  );
    if (ch == CH_AUX) begin
      mux_for = fc[FC_SRC_BIT] ? MUX_BRICK : MUX_AUX_PINS;    // [R5]
    end else begin
      mux_for = mux_src_e'(ch);                                // [R4]
    end
    return mux_for;
  endfunction

  // reference for a channel
  function automatic ref_src_e ref_for(
    input logic [3:0] ch,
    input logic [7:0] fc
  );
    if (ch == CH_TS1 || ch == CH_TS2) begin
      ref_for = REF_REG_DIV;                                   // [R12]
    end else if (ch == CH_AUX) begin
      // brick always on the bandgap, whatever the reference bit says
      ref_for = (fc[FC_SRC_BIT] || fc[FC_REF_BIT]) ?          // [R7] [R16]
                REF_BANDGAP : REF_REGULATOR;                   // [R6] [R15]
    end else begin
      ref_for = REF_BANDGAP;                                   // [R14]
    end
    return ref_for;
  endfunction

  // control and status state
  seq_state_e    state_reg, state_next;
  logic [3:0]    ch_reg, ch_next;
  logic [7:0]    start_request_bit_ctrl_reg;
  logic [7:0]    io_ctrl_reg;
  logic [7:0]    func_cfg_reg;
  logic          start_bit_reg, start_bit_next;
  logic          pin_q_reg;
  logic          ready_reg, ready_next;
  logic          adc_start_reg, adc_start_next;
  mux_src_e      mux_reg, mux_next;
  ref_src_e      ref_reg, ref_next;
  logic [7:0]    rd_data_reg;
  logic          busy_reg, busy_next;
  logic [RESULT_W-1:0] result_mem [CH_COUNT];

  wire [RESULT_W-1:0] sat_word;
  wire [CH_COUNT-1:0] en_mask;
  wire [3:0]          first_ch;
  wire [3:0]          after_ch;
  wire                pin_rise;
  wire                start_req;
  wire                store_now;
  wire                seq_last;
  wire                wr_start_request_bit, wr_io, wr_cfg, wr_start;
  wire [7:0]          pair_off;
  wire [3:0]          pair_idx;
  wire [3:0]          rd_ch;
  wire                in_results;
  wire [RESULT_W-1:0] rd_word;
  wire [7:0]          status_byte;
  wire [7:0]          rd_byte;

  result_saturate #(
    .TRIM_W   (TRIM_W)
  ) u_sat (
    .clk      (clk),
    .nrst     (nrst),
    .raw_code (adc_code),
    .trim     (adc_trim),
    .word     (sat_word)
  );

  // register write decode
  assign wr_start_request_bit  = reg_wr_en && reg_addr == OFF_START_REQUEST_BIT_CTRL;
  assign wr_io    = reg_wr_en && reg_addr == OFF_IO_CTRL;
  assign wr_cfg   = reg_wr_en && reg_addr == OFF_FUNC_CFG;
  assign wr_start = reg_wr_en && reg_addr == OFF_START
                    && reg_wr_data[START_BIT];

  // start requests; the register bit only works while the pin rests low
  assign pin_rise  = host_start_pin && !pin_q_reg;
  assign start_req = state_reg == SEQ_IDLE &&                  // [R18]
                     (pin_rise || (start_bit_reg && !host_start_pin));

  // channel walk over the enabled set
  assign en_mask   = enabled_mask(start_request_bit_ctrl_reg);              // [R8]
  assign first_ch  = next_enabled(en_mask, CH_CELL1);
  assign after_ch  = next_enabled(en_mask, ch_reg + 4'h1);
  assign store_now = state_reg == SEQ_WAIT && adc_done;
  assign seq_last  = store_now && after_ch == CH_NONE;

  // sequencer next state
  always_comb begin
    state_next     = state_reg;
    ch_next        = ch_reg;
    adc_start_next = 1'b0;
    mux_next       = mux_reg;
    ref_next       = ref_reg;
    unique case (state_reg)
      SEQ_IDLE: begin
        if (start_req && first_ch != CH_NONE) begin
          ch_next    = first_ch;
          state_next = SEQ_ISSUE;
        end
      end
      SEQ_ISSUE: begin
        mux_next       = mux_for(ch_reg, func_cfg_reg);
        ref_next       = ref_for(ch_reg, func_cfg_reg);
        adc_start_next = 1'b1;
        state_next     = SEQ_WAIT;
      end
      SEQ_WAIT: begin
        if (store_now) begin
          if (seq_last) begin
            state_next = SEQ_IDLE;
          end else begin
            ch_next    = after_ch;                             // [R18]
            state_next = SEQ_ISSUE;
          end
        end
      end
      default: state_next = SEQ_IDLE;
    endcase
  end

  // busy kept in its own flop so the pin never carries decode glitches
  assign busy_next = state_next != SEQ_IDLE;

  // ready: the set wins over a pin edge landing in the same cycle
  // an empty enabled set still completes at once so the host sees ready
  assign ready_next = (seq_last || (start_req && first_ch == CH_NONE))
                      ? 1'b1 : (pin_rise ? 1'b0 : ready_reg);  // [R19]

  // start bit is write-one only, cleared by the block when a walk ends
  assign start_bit_next = wr_start ? 1'b1 :
                          (seq_last || (start_req && first_ch == CH_NONE))
                          ? 1'b0 : start_bit_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg     <= SEQ_IDLE;
      ch_reg        <= CH_CELL1;
      adc_start_reg <= 1'b0;
      mux_reg       <= MUX_CELL1;
      ref_reg       <= REF_BANDGAP;
      ready_reg     <= 1'b0;
      start_bit_reg <= 1'b0;
      pin_q_reg     <= 1'b0;
      busy_reg      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      ch_reg        <= ch_next;
      adc_start_reg <= adc_start_next;
      mux_reg       <= mux_next;
      ref_reg       <= ref_next;
      ready_reg     <= ready_next;
      start_bit_reg <= start_bit_next;
      pin_q_reg     <= host_start_pin;
      busy_reg      <= busy_next;
    end
  end

  // writable control registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      start_request_bit_ctrl_reg <= START_REQUEST_BIT_CTRL_RST;
      io_ctrl_reg   <= IO_CTRL_RST;
      func_cfg_reg  <= FUNC_CFG_RST;
    end else begin
      if (wr_start_request_bit) start_request_bit_ctrl_reg <= reg_wr_data;
      if (wr_io)   io_ctrl_reg   <= reg_wr_data;               // [R10]
      if (wr_cfg)  func_cfg_reg  <= reg_wr_data;
    end
  end

  // whole word stored in one edge so a read never mixes two conversions
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < CH_COUNT; i++) begin
        result_mem[i] <= '0;
      end
    end else if (store_now) begin
      result_mem[ch_reg] <= sat_word;                          // [R20]
    end
  end

  // read decode: odd offsets hold the high byte of each pair
  assign in_results = reg_addr >= OFF_AUX_HI
                      && reg_addr <= OFF_RESULT_LAST;
  assign pair_off   = reg_addr - OFF_AUX_HI;
  assign pair_idx   = pair_off[4:1];
  assign rd_ch      = !in_results ? CH_CELL1 :
                      (pair_idx == 4'h0 ? CH_AUX : pair_idx - 4'h1);
  assign rd_word    = result_mem[rd_ch];
  assign status_byte = {6'h00, state_reg != SEQ_IDLE, ready_reg};
  assign rd_byte    = in_results ?
                        (pair_off[0] ? rd_word[7:0] : rd_word[15:8]) : // [R2]
                      reg_addr == OFF_STATUS    ? status_byte :
                      reg_addr == OFF_START_REQUEST_BIT_CTRL ? start_request_bit_ctrl_reg :
                      reg_addr == OFF_IO_CTRL   ? io_ctrl_reg :
                      reg_addr == OFF_FUNC_CFG  ? func_cfg_reg :
                      reg_addr == OFF_START     ? {7'h00, start_bit_reg} :
                      8'h00;

  // read data holds until the next read strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_reg <= 8'h00;
    end else if (reg_rd_en) begin
      rd_data_reg <= rd_byte;
    end
  end

  // every output comes from a flop
  assign reg_rd_data      = rd_data_reg;
  assign adc_mux_sel      = mux_reg;
  assign adc_ref_sel      = ref_reg;
  assign adc_start        = adc_start_reg;
  assign therm_switch     = {io_ctrl_reg[IO_TS2_BIT],          // [R10]
                             io_ctrl_reg[IO_TS1_BIT]};
  assign result_ready_out = ready_reg;
  assign busy             = busy_reg;

  // checks on the sequencer, references and register image
  wire [RESULT_W-1:0] cell1_word = result_mem[0];
  wire [2:0]          cell_lim   = (start_request_bit_ctrl_reg[2:0] > CELL_COUNT_ALL)
                                   ? CELL_COUNT_ALL : start_request_bit_ctrl_reg[2:0];

  ready_set_a: assert property (@(posedge clk) disable iff (!nrst) // [R19]
    seq_last |=> result_ready_out)
    else $error("ready not raised after the last store");

  ready_clr_a: assert property (@(posedge clk) disable iff (!nrst) // [R19]
    (pin_rise && !seq_last && !start_req) |=> !result_ready_out)
    else $error("ready not cleared by a start pin rising edge");

  brick_ref_a: assert property (@(posedge clk) disable iff (!nrst) // [R7]
    (adc_start && adc_mux_sel == MUX_BRICK) |-> adc_ref_sel == REF_BANDGAP)
    else $error("brick conversion not on the bandgap");

  therm_ref_a: assert property (@(posedge clk) disable iff (!nrst) // [R12]
    (adc_start && (adc_mux_sel == MUX_THERM1 || adc_mux_sel == MUX_THERM2))
      |-> adc_ref_sel == REF_REG_DIV)
    else $error("thermistor conversion not on the divided regulator");

  cell_limit_a: assert property (@(posedge clk) disable iff (!nrst) // [R8]
    (adc_start && ch_reg < CH_TS1) |-> ch_reg[2:0] <= cell_lim)
    else $error("scan reached a cell beyond the cell count");

  cell_byte_a: assert property (@(posedge clk) disable iff (!nrst) // [R2]
    (reg_rd_en && reg_addr == OFF_CELL1_LO)
      |=> reg_rd_data == $past(cell1_word[7:0]))
    else $error("cell one low byte not at its offset");

  top_zero_a: assert property (@(posedge clk) disable iff (!nrst) // [R1]
    (reg_rd_en && reg_addr == OFF_CELL1_HI) |=> reg_rd_data[7:6] == 2'b00)
    else $error("result high byte has nonzero top bits");

  excite_a: assert property (@(posedge clk) disable iff (!nrst) // [R10]
    wr_io |=> therm_switch == $past(reg_wr_data[1:0]))
    else $error("excitation switches do not follow the register");

  start_clr_a: assert property (@(posedge clk) disable iff (!nrst) // [R18]
    (seq_last && !wr_start) |=> !start_bit_reg && !busy)
    else $error("start bit or busy left set after the sequence");

  full_seq_c: cover property (@(posedge clk) disable iff (!nrst)
    start_req ##[1:200] seq_last);

  brick_c: cover property (@(posedge clk) disable iff (!nrst)
    adc_start && adc_mux_sel == MUX_BRICK);

  therm_c: cover property (@(posedge clk) disable iff (!nrst)
    adc_start && adc_mux_sel == MUX_THERM2);

  aux_ratio_c: cover property (@(posedge clk) disable iff (!nrst)
    adc_start && adc_ref_sel == REF_REGULATOR);

  clamp_c: cover property (@(posedge clk) disable iff (!nrst)
    store_now && sat_word == '0);

  // cell one is always in the scan, so every walk opens on it
  first_cell_a: assert property (@(posedge clk) disable iff (!nrst) // [R17]
    (start_req && first_ch != CH_NONE) |=> ch_reg == CH_CELL1)
    else $error("walk did not open on cell one");

  result_store_a: assert property (@(posedge clk) disable iff (!nrst) // [R20]
    store_now |=> result_mem[$past(ch_reg)] == $past(sat_word))
    else $error("result word not stored whole at the done edge");

endmodule
`default_nettype wire

// [hw/adc_ctrl_pkg.sv]
// constants, field layouts and enumerations for the converter control block
// How it works
// [R1] results are 14-bit magnitudes in a 16-bit word, top two bits zero
// [R2] each word sits big-endian in a byte pair; cell one at 0x03/0x04
// [R3] offset correction saturates at zero and full scale, never wraps
// [R4] the front multiplexer offers six cells, two thermistors, one auxiliary
// [R5] aux source select 1 routes the brick voltage into the aux result
// [R6] aux reference select 1 picks the bandgap, else the regulator output
// [R7] brick measurement forces the bandgap and ignores aux reference select
// [R8] the cell-count field limits the scan to connected cells
// [R9] a thermistor enable bit adds that channel to the next sequence
// [R10] a thermistor excitation bit closes its ground switch
// [R11] the host should set excitation bits only while measuring
// [R12] thermistor conversions use the divided regulator as reference
// [R13] thermistor readings are clamped between 0 and 16383
// [R14] cell full scale 16383 corresponds to 6250 mV
// [R15] aux full scale with bandgap corresponds to 2500 mV
// [R16] brick full scale corresponds to about 33.333 V
// [R17] cell-count code 0 scans cell one, each step adds one, 5 is all six
// [R18] a start from pin or register bit steps through every enabled channel
// [R19] ready rises when the last result is stored, clears on pin rising edge
// [R20] both bytes of a result pair are written together
package adc_ctrl_pkg;

  localparam int CODE_W   = 14;
  localparam int RESULT_W = 16;
  localparam int CH_COUNT = 9;

  // channel indices in scan order
  localparam logic [3:0] CH_CELL1 = 4'h0;
  localparam logic [3:0] CH_TS1   = 4'h6;
  localparam logic [3:0] CH_TS2   = 4'h7;
  localparam logic [3:0] CH_AUX   = 4'h8;
  localparam logic [3:0] CH_NONE  = 4'h9;

  localparam logic [2:0]  CELL_COUNT_ALL = 3'h5;
  localparam logic [13:0] CODE_MAX       = 14'h3fff;

  // full-scale figures set by the analog gain ahead of the converter
  localparam int CELL_FS_MV  = 6250;
  localparam int AUX_FS_MV   = 2500;
  localparam int BRICK_FS_MV = 33333;

  // byte register map
  localparam logic [7:0] OFF_STATUS      = 8'h00;
  localparam logic [7:0] OFF_AUX_HI      = 8'h01;
  localparam logic [7:0] OFF_CELL1_HI    = 8'h03;
  localparam logic [7:0] OFF_CELL1_LO    = 8'h04;
  localparam logic [7:0] OFF_THERM1_HI   = 8'h0f;
  localparam logic [7:0] OFF_THERM1_LO   = 8'h10;
  localparam logic [7:0] OFF_RESULT_LAST = 8'h12;
  localparam logic [7:0] OFF_START_REQUEST_BIT_CTRL   = 8'h30;
  localparam logic [7:0] OFF_IO_CTRL     = 8'h31;
  localparam logic [7:0] OFF_START       = 8'h34;
  localparam logic [7:0] OFF_FUNC_CFG    = 8'h40;

  // field positions
  localparam int CC_CELL_LSB    = 0;
  localparam int CC_CELL_MSB    = 2;
  localparam int CC_TS1_BIT     = 4;
  localparam int CC_TS2_BIT     = 5;
  localparam int CC_AUX_BIT     = 6;
  localparam int IO_TS1_BIT     = 0;
  localparam int IO_TS2_BIT     = 1;
  localparam int FC_SRC_BIT     = 4;
  localparam int FC_REF_BIT     = 5;
  localparam int START_BIT      = 0;
  localparam int ST_READY_BIT   = 0;
  localparam int ST_BUSY_BIT    = 1;

  // reset values
  localparam logic [7:0] START_REQUEST_BIT_CTRL_RST = 8'h00;
  localparam logic [7:0] IO_CTRL_RST   = 8'h00;
  localparam logic [7:0] FUNC_CFG_RST  = 8'h00;

  typedef enum logic [3:0] {
    MUX_CELL1     = 4'b0000,
    MUX_CELL2     = 4'b0001,
    MUX_CELL3     = 4'b0010,
    MUX_CELL4     = 4'b0011,
    MUX_CELL5     = 4'b0100,
    MUX_CELL6     = 4'b0101,
    MUX_THERM1    = 4'b0110,
    MUX_THERM2    = 4'b0111,
    MUX_AUX_PINS  = 4'b1000,
    MUX_BRICK     = 4'b1001
  } mux_src_e;

  typedef enum logic [1:0] {
    REF_BANDGAP   = 2'b00,
    REF_REGULATOR = 2'b01,
    REF_REG_DIV   = 2'b10
  } ref_src_e;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_ISSUE = 2'b01,
    SEQ_WAIT  = 2'b10
  } seq_state_e;

endpackage

// [hw/result_saturate.sv]
// offset correction of a raw converter code with clamping at both ends
`timescale 1ns/1ps
`default_nettype none
module result_saturate #(
  parameter int TRIM_W = 8
) (
  input  wire logic                              clk,
  input  wire logic                              nrst,
  input  wire logic [adc_ctrl_pkg::CODE_W-1:0]   raw_code,
  input  wire logic signed [TRIM_W-1:0]          trim,
  output logic      [adc_ctrl_pkg::RESULT_W-1:0] word
);
  import adc_ctrl_pkg::*;

  logic signed [RESULT_W:0] sum;
  wire                      below_zero;
  wire                      above_max;

  // one extra bit of headroom so the sum itself can never wrap
  assign sum = $signed({3'b000, raw_code}) + (RESULT_W+1)'(trim);
  assign below_zero = sum < 0;
  assign above_max  = sum > $signed({3'b000, CODE_MAX});

  // clamp rather than wrap, then pad the top two bits with zero
  assign word = below_zero ? '0 :                              // [R3]
                above_max  ? {2'b00, CODE_MAX} :                // [R13]
                {2'b00, sum[CODE_W-1:0]};                       // [R1]

  sat_low_a: assert property (@(posedge clk) disable iff (!nrst) // [R3]
    (int'(raw_code) + int'(trim) < 0) |-> word == '0)
    else $error("negative corrected code did not clamp to zero");

  sat_high_a: assert property (@(posedge clk) disable iff (!nrst) // [R13]
    ({3'b000, raw_code} + (RESULT_W+1)'(trim) > {3'b000, CODE_MAX}
      && trim > 0) |-> word == {2'b00, CODE_MAX})
    else $error("corrected code above full scale did not clamp");

endmodule
`default_nettype wire

// [test/adc_model.sv]
// converter stand-in: answers each start with a channel-coded result
`timescale 1ns/1ps
`default_nettype none
module adc_model (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   adc_start,
  input  wire adc_ctrl_pkg::mux_src_e adc_mux_sel,
  input  wire logic                   slow,
  output logic                        adc_done,
  output logic [13:0]                 adc_code
);
  import adc_ctrl_pkg::*;
  logic [4:0] cnt_reg;
  logic [3:0] ch_reg;
  // cells one, two and thermistor one sit near the ends so trim clamps
  function automatic logic [13:0] code_of(input logic [3:0] m);
    if (m == 4'h0) return 14'h0005;
    if (m == 4'h1) return 14'h3ffd;
    if (m == 4'h6) return 14'h3ff0;
    return {m, 10'h05a};
  endfunction
  // code is valid only with done; elsewhere it toggles so stale data fails
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg  <= 5'h00;
      ch_reg   <= 4'h0;
      adc_done <= 1'b0;
      adc_code <= 14'h0000;
    end else begin
      adc_done <= 1'b0;
      adc_code <= ~adc_code;
      if (adc_start) begin
        cnt_reg <= slow ? 5'h14 : 5'h03;
        ch_reg  <= adc_mux_sel;
      end else if (cnt_reg == 5'h01) begin
        adc_done <= 1'b1;
        adc_code <= code_of(ch_reg);
        cnt_reg  <= 5'h00;
      end else if (cnt_reg != 5'h00) begin
        cnt_reg <= cnt_reg - 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// [test/tb.sv]
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import adc_ctrl_pkg::*;
  logic              clk;
  logic              nrst;
  logic [7:0]        reg_addr;
  logic              reg_wr_en;
  logic [7:0]        reg_wr_data;
  logic              reg_rd_en;
  logic [7:0]        reg_rd_data;
  logic              host_start_pin;
  logic              adc_done;
  logic [13:0]       adc_code;
  logic signed [7:0] adc_trim;
  mux_src_e          adc_mux_sel;
  ref_src_e          adc_ref_sel;
  logic              adc_start;
  logic [1:0]        therm_switch;
  logic              result_ready_out;
  logic              busy;
  logic              slow;
  int                n_fail;
  int                checked;
  logic [5:0]        seen[$];
  logic [5:0]        want[$];

  cell_monitor_adc_control dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .host_start_pin(host_start_pin),
    .adc_done(adc_done), .adc_code(adc_code), .adc_trim(adc_trim),
    .adc_mux_sel(adc_mux_sel), .adc_ref_sel(adc_ref_sel),
    .adc_start(adc_start), .therm_switch(therm_switch),
    .result_ready_out(result_ready_out), .busy(busy));
  adc_model start_request_bit (.clk(clk), .nrst(nrst), .adc_start(adc_start),
    .adc_mux_sel(adc_mux_sel), .slow(slow), .adc_done(adc_done),
    .adc_code(adc_code));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // log channel and reference of every converter start
  always @(posedge clk) begin
    if (adc_start === 1'b1) seen.push_back({adc_mux_sel, adc_ref_sel});
  end

  task automatic stop_test();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr_en   <= 1'b1;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    @(posedge clk);
    d = reg_rd_data;
  endtask
  // both bytes of a pair, high byte at the lower offset
  task automatic rd16(input logic [7:0] a, output logic [15:0] w);
    logic [7:0] h;
    logic [7:0] l;
    rd(a, h);
    rd(a + 8'h01, l);
    w = {h, l};
  endtask
  // saturated result word expected for a channel under the current trim
  function automatic logic [15:0] exp_word(input logic [3:0] m);
    int v;
    v = (m == 4'h0) ? 5 : (m == 4'h1) ? 16381 :
        (m == 4'h6) ? 16368 : int'({m, 10'h05a});
    v = v + int'(adc_trim);
    if (v < 0) v = 0;
    if (v > 16383) v = 16383;
    return 16'(v);
  endfunction
  // start from pin or bit, then wait for the walk to finish, bounded
  task automatic run(input logic by_pin);
    int i;
    seen.delete();
    if (by_pin) begin
      @(posedge clk);
      host_start_pin <= 1'b1;
    end else begin
      wr(OFF_START, 8'h01);
    end
    for (i = 0; i < 20 && busy !== 1'b1; i++) @(posedge clk);
    chk(16'(busy), 16'h0001);
    if (by_pin) chk(16'(result_ready_out), 16'h0000);
    for (i = 0; i < 2000 && (busy !== 1'b0 || result_ready_out !== 1'b1);
         i++) @(posedge clk);
    chk(16'({busy, result_ready_out}), 16'h0001);
    if (i == 2000) stop_test();
    host_start_pin <= 1'b0;
  endtask
  task automatic chk_seq();
    chk(16'(seen.size()), 16'(want.size()));
    foreach (want[k]) if (k < seen.size()) chk(16'(seen[k]), 16'(want[k]));
  endtask

  task automatic t_reset();
    logic [7:0] d;
    logic [7:0] a[7] = '{OFF_STATUS, OFF_CELL1_HI, OFF_CELL1_LO, OFF_START_REQUEST_BIT_CTRL,
                         OFF_IO_CTRL, OFF_FUNC_CFG, 8'h20};
    wr(OFF_CELL1_HI, 8'hff);
    foreach (a[k]) begin
      rd(a[k], d);
      chk(16'(d), 16'h0000);
    end
    chk(16'({therm_switch, result_ready_out}), 16'h0000);
    $display("test reset done");
  endtask
  // every cell count, alternating start source and trim sign
  task automatic t_cells();
    logic [15:0] w;
    logic [7:0]  d;
    for (int n = 0; n < 7; n++) begin
      adc_trim <= n[0] ? 8'sd20 : -8'sd20;
      wr(OFF_START_REQUEST_BIT_CTRL, 8'(n));
      run(n[0]);
      want.delete();
      for (int k = 0; k <= n && k < 6; k++) begin
        want.push_back({4'(k), REF_BANDGAP});
      end
      chk_seq();
      for (int k = 0; k <= n && k < 6; k++) begin
        rd16(OFF_CELL1_HI + 8'(2 * k), w);
        chk(w, exp_word(4'(k)));
      end
      rd(OFF_STATUS, d);
      chk(16'(d), 16'h0001);
      rd(OFF_START, d);
      chk(16'(d), 16'h0000);
    end
    $display("test cells done");
  endtask
  task automatic t_therm();
    logic [15:0] w;
    adc_trim <= 8'sd20;
    wr(OFF_IO_CTRL, 8'h03);
    @(posedge clk);
    chk(16'(therm_switch), 16'h0003);
    wr(OFF_START_REQUEST_BIT_CTRL, 8'h30);
    run(1'b1);
    slow <= 1'b1;
    run(1'b1);
    slow <= 1'b0;
    want.delete();
    want.push_back({MUX_CELL1, REF_BANDGAP});
    want.push_back({MUX_THERM1, REF_REG_DIV});
    want.push_back({MUX_THERM2, REF_REG_DIV});
    chk_seq();
    rd16(OFF_THERM1_HI, w);
    chk(w, exp_word(4'h6));
    rd16(OFF_THERM1_HI + 8'h02, w);
    chk(w, exp_word(4'h7));
    wr(OFF_IO_CTRL, 8'h00);
    @(posedge clk);
    chk(16'(therm_switch), 16'h0000);
    $display("test thermistor done");
  endtask
  // all four source and reference combinations of the auxiliary input
  task automatic t_aux();
    logic [15:0] w;
    mux_src_e    m;
    ref_src_e    r;
    wr(OFF_START_REQUEST_BIT_CTRL, 8'h40);
    for (int k = 0; k < 4; k++) begin
      wr(OFF_FUNC_CFG, {2'b00, k[1], k[0], 4'h0});
      run(1'b0);
      m = k[0] ? MUX_BRICK : MUX_AUX_PINS;
      r = (k[0] | k[1]) ? REF_BANDGAP : REF_REGULATOR;
      want.delete();
      want.push_back({MUX_CELL1, REF_BANDGAP});
      want.push_back({m, r});
      chk_seq();
      rd16(OFF_AUX_HI, w);
      chk(w, exp_word(m));
    end
    $display("test aux done");
  endtask

  initial begin
    n_fail         = 0;
    checked        = 0;
    nrst           = 1'b0;
    reg_addr       = 8'h00;
    reg_wr_en      = 1'b0;
    reg_wr_data    = 8'h00;
    reg_rd_en      = 1'b0;
    host_start_pin = 1'b0;
    adc_trim       = 8'sd0;
    slow           = 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_cells();
    t_therm();
    t_aux();
    stop_test();
  end
endmodule
`default_nettype wire
